// ---- src/aucs_pkg.sv ----
// Package for the upper configuration and status register group.
// Assumes byte-wide registers reached by a byte address on the device interface.
package aucs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_RESERVED_PAD = 8'h0F;
  localparam logic [7:0] OFS_INPUT_GAIN = 8'h10;
  localparam logic [7:0] OFS_ALARM_FLAGS = 8'h11;
  localparam logic [7:0] OFS_LOCK_STATUS = 8'h12;
  localparam logic [7:0] OFS_HOST_CMD = 8'h00;
  localparam logic [7:0] OFS_HOST_STAT = 8'h01;
  localparam logic [7:0] OFS_HOST_INT_MASK = 8'h02;
  localparam logic [7:0] OFS_HOST_INT_STAT = 8'h03;
  localparam logic [7:0] OFS_HOST_ADDR = 8'h04;
  localparam logic [7:0] OFS_HOST_WDATA = 8'h05;
  localparam logic [7:0] OFS_HOST_RDATA = 8'h06;
  localparam logic [7:0] RST_RESERVED_PAD = 8'h00;
  localparam logic [7:0] RST_INPUT_GAIN = 8'h50;
  localparam logic [7:0] RST_ALARM_FLAGS = 8'h00;
  localparam int GAIN_SEL_MSB = 6;
  localparam int GAIN_SEL_LSB = 4;
  localparam int GAIN_CODE_MSB = 3;
  localparam int GAIN_CODE_LSB = 0;
  localparam int LOCK_BIT = 5;
  localparam int CHECK_ERR_BIT = 4;
  localparam logic [7:0] INPUT_GAIN_WMASK = 8'h7F;
  localparam logic [2:0] SEL_RESERVED = 3'h7;
  localparam logic [3:0] GAIN_MAX = 4'hB;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_REFUSED_BIT = 1;
endpackage

// ---- src/aucs_if.sv ----
// Interface joining the host controller and the register group.
// Assumes both ends share clk_i and reset_i.
`timescale 1ns/1ps
`default_nettype none
interface aucs_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ---- src/aucs_dev.sv ----
// Device end: upper register group with inputs, gain, alarms and status.
// Assumes host strobes are one cycle and never overlap; read data next cycle.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Pad byte 0Fh reads zero, write zero
// - Byte 10h resets 50h, bit 7 zero
// - Bits 6:4 select the measured input
// - Host never programs input code 111
// - Bits 3:0 select amplifier gain code
// - Byte 11h holds eight amplifier alarms
// - Alarms held set, cleared by read
// - Byte 12h bits 7:6 read zero
// - Bit 5 shows upper write lock
// - Write lock reads zero after reset
// - Bit 4 sets on second path error
// - Check error cleared only by zero write
// - Bits 3:0 read revision nibble
module aucs_dev
  import aucs_pkg::*;
#(
  // Arbitrary neutral value
  parameter logic [3:0] REVISION_NIBBLE = REVISION_DEFAULT
) (
  input wire logic clk_i,
  input wire logic reset_i,
  aucs_if.dev bus,
  input wire logic [7:0] alarm_event_i,
  input wire logic check_error_i,
  input wire logic lock_set_i,
  input wire logic lock_clear_i,
  output logic [2:0] input_select_o,
  output logic [3:0] gain_code_o,
  output logic upper_write_lock_flag_o
);
  typedef struct packed {
    logic [7:0] input_gain;
    logic [7:0] alarms;
    logic lock;
    logic check_err;
    logic [7:0] rdata;
  } aucs_dev_state_type;

  aucs_dev_state_type s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    // Writes to the group are ignored while locked
    if (bus.wr && !s_q.lock) begin
      case (bus.addr)
        OFS_INPUT_GAIN: s_d.input_gain = bus.wdata & INPUT_GAIN_WMASK;
        OFS_LOCK_STATUS: begin
          if (!bus.wdata[CHECK_ERR_BIT]) begin
            s_d.check_err = 1'b0;
          end
        end
        default: s_d.rdata = 8'h00;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        OFS_RESERVED_PAD: s_d.rdata = RST_RESERVED_PAD;
        OFS_INPUT_GAIN: s_d.rdata = s_q.input_gain;
        OFS_ALARM_FLAGS: begin
          s_d.rdata = s_q.alarms;
          s_d.alarms = 8'h00;
        end
        OFS_LOCK_STATUS: begin
          s_d.rdata = {2'b00, s_q.lock, s_q.check_err, REVISION_NIBBLE};
        end
        default: s_d.rdata = 8'h00;
      endcase
    end
    // New events win over the clearing access
    s_d.alarms = s_d.alarms | alarm_event_i;
    if (check_error_i) begin
      s_d.check_err = 1'b1;
    end
    if (lock_set_i) begin
      s_d.lock = 1'b1;
    end else if (lock_clear_i) begin
      s_d.lock = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q.input_gain <= RST_INPUT_GAIN;
      s_q.alarms <= RST_ALARM_FLAGS;
      s_q.lock <= 1'b0;
      s_q.check_err <= 1'b0;
      s_q.rdata <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.rdata = s_q.rdata;
  assign input_select_o = s_q.input_gain[GAIN_SEL_MSB:GAIN_SEL_LSB];
  assign gain_code_o = s_q.input_gain[GAIN_CODE_MSB:GAIN_CODE_LSB];
  assign upper_write_lock_flag_o = s_q.lock;
endmodule
`default_nettype wire

// ---- src/aucs_host.sv ----
// Host end: executes one register read or write ordered by software.
// Assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module aucs_host
  import aucs_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  aucs_if.host bus,
  input wire logic [7:0] sw_addr_i,
  input wire logic [7:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [7:0] sw_rdata_o,
  output logic irq_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } aucs_host_fsm_type;

  typedef struct packed {
    aucs_host_fsm_type fsm;
    logic [7:0] tgt_addr;
    logic [7:0] tgt_wdata;
    logic is_read;
    logic [7:0] result;
    logic refused;
    logic [1:0] int_mask;
    logic [1:0] int_stat;
    logic [7:0] sw_rdata;
    logic irq;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } aucs_host_state_type;

  aucs_host_state_type s_q, s_d;
  logic [7:0] clean_wdata;
  logic bad_write;

  always_comb begin
    s_d = s_q;
    s_d.sw_rdata = 8'h00;
    s_d.wr = 1'b0;
    s_d.rd = 1'b0;
    clean_wdata = s_q.tgt_wdata;
    bad_write = 1'b0;
    // Reserved fields always written as zero
    case (s_q.tgt_addr)
      OFS_RESERVED_PAD: clean_wdata = 8'h00;
      OFS_INPUT_GAIN: begin
        clean_wdata = s_q.tgt_wdata & INPUT_GAIN_WMASK;
        bad_write = clean_wdata[GAIN_SEL_MSB:GAIN_SEL_LSB] == SEL_RESERVED;
      end
      OFS_LOCK_STATUS: clean_wdata = {2'b00, 1'b0, s_q.tgt_wdata[CHECK_ERR_BIT], 4'h0};
      default: clean_wdata = s_q.tgt_wdata;
    endcase
    case (s_q.fsm)
      ST_IDLE: s_d.fsm = ST_IDLE;
      ST_ISSUE: begin
        if (!s_q.is_read && bad_write) begin
          s_d.refused = 1'b1;
          s_d.int_stat[EV_REFUSED_BIT] = 1'b1;
          s_d.fsm = ST_IDLE;
        end else begin
          s_d.refused = 1'b0;
          s_d.addr = s_q.tgt_addr;
          s_d.wdata = clean_wdata;
          s_d.wr = !s_q.is_read;
          s_d.rd = s_q.is_read;
          s_d.fsm = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!s_q.wr && !s_q.rd) begin
          if (s_q.is_read) begin
            s_d.result = bus.rdata;
          end
          s_d.int_stat[EV_DONE_BIT] = 1'b1;
          s_d.fsm = ST_IDLE;
        end
      end
      default: s_d.fsm = ST_IDLE;
    endcase
    if (sw_rd_i) begin
      case (sw_addr_i)
        OFS_HOST_STAT: s_d.sw_rdata = {6'h00, s_q.refused, s_q.fsm != ST_IDLE};
        OFS_HOST_INT_MASK: s_d.sw_rdata = {6'h00, s_q.int_mask};
        OFS_HOST_INT_STAT: begin
          s_d.sw_rdata = {6'h00, s_q.int_stat};
          // Events of this same cycle survive the clear only in bits that read as zero
          s_d.int_stat = s_d.int_stat & ~s_q.int_stat;
        end
        OFS_HOST_ADDR: s_d.sw_rdata = s_q.tgt_addr;
        OFS_HOST_WDATA: s_d.sw_rdata = s_q.tgt_wdata;
        OFS_HOST_RDATA: s_d.sw_rdata = s_q.result;
        default: s_d.sw_rdata = 8'h00;
      endcase
    end
    if (sw_wr_i) begin
      case (sw_addr_i)
        OFS_HOST_CMD: begin
          // Orders given while busy are dropped
          if (s_q.fsm == ST_IDLE && (sw_wdata_i[CMD_WRITE_BIT] || sw_wdata_i[CMD_READ_BIT])) begin
            s_d.is_read = sw_wdata_i[CMD_READ_BIT];
            s_d.fsm = ST_ISSUE;
          end
        end
        OFS_HOST_INT_MASK: s_d.int_mask = sw_wdata_i[1:0];
        OFS_HOST_ADDR: s_d.tgt_addr = sw_wdata_i;
        OFS_HOST_WDATA: s_d.tgt_wdata = sw_wdata_i;
        default: s_d.int_mask = s_d.int_mask;
      endcase
    end
    s_d.irq = |(s_d.int_stat & s_d.int_mask);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '{fsm: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.addr = s_q.addr;
  assign bus.wdata = s_q.wdata;
  assign bus.wr = s_q.wr;
  assign bus.rd = s_q.rd;
  assign sw_rdata_o = s_q.sw_rdata;
  assign irq_o = s_q.irq;
endmodule
`default_nettype wire

// ---- dv/aucs_sva.sv ----
// Checker on the bus joining host and register group.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module aucs_sva #(
  parameter logic [3:0] REV = 4'h1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  chk_pad_read_zero: assert property (rd && addr == 8'h0F |=> rdata == 8'h00)
    else $error("pad read");
  chk_pad_write_zero: assert property (wr && addr == 8'h0F |-> wdata == 8'h00)
    else $error("pad write");
  chk_sel_write_legal: assert property (wr && addr == 8'h10 |-> wdata[6:4] != 3'h7)
    else $error("input code");
  chk_gain_read_msb: assert property (rd && addr == 8'h10 |=> !rdata[7])
    else $error("gain msb");
  chk_stat_write_rsvd: assert property (wr && addr == 8'h12 |-> wdata[7:6] == 2'h0)
    else $error("status write");
  chk_stat_read_rsvd: assert property (rd && addr == 8'h12 |=> rdata[7:6] == 2'h0)
    else $error("status read");
  chk_rev_read_fixed: assert property (rd && addr == 8'h12 |=> rdata[3:0] == REV)
    else $error("revision");
  chk_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("idle data");
  cov_alarm_read: cover property (rd && addr == 8'h11 ##1 rdata != 8'h00);
  cov_gain_write: cover property (wr && addr == 8'h10);
  cov_stat_write: cover property (wr && addr == 8'h12);
endmodule
`default_nettype wire

// ---- dv/adc_upper_config_status_regs_tb.sv ----
// Bench: host and register group back to back, driven from the software port.
// Assumes 50 MHz clock and a 10-cycle synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module adc_upper_config_status_regs_tb;
  import aucs_pkg::*;
  logic clk_i = 0, reset_i = 1, sw_wr_i = 0, sw_rd_i = 0, irq, flag;
  logic ce = 0, ls = 0, lc = 0;
  logic [7:0] sw_addr_i = 0, sw_wdata_i = 0, sw_rdata_o, ev = 0, r;
  logic [2:0] sel;
  logic [3:0] gain;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  aucs_if bus ();
  aucs_dev i_aucs_dev (.clk_i, .reset_i, .bus(bus.dev), .alarm_event_i(ev), .check_error_i(ce),
    .lock_set_i(ls), .lock_clear_i(lc), .input_select_o(sel), .gain_code_o(gain),
    .upper_write_lock_flag_o(flag));
  aucs_host i_aucs_host (.clk_i, .reset_i, .bus(bus.host), .sw_addr_i, .sw_wdata_i, .sw_wr_i,
    .sw_rd_i, .sw_rdata_o, .irq_o(irq));
  aucs_sva #(.REV(REVISION_DEFAULT)) i_aucs_sva (.clk_i, .reset_i, .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Strobe dropped for a cycle so no signal is assigned twice in one step
  task automatic swr(input logic [7:0] a, input logic [7:0] d);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic srd(input logic [7:0] a);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    #1 r = sw_rdata_o;
    @(posedge clk_i);
  endtask
  task automatic dop(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
    swr(OFS_HOST_ADDR, a);
    swr(OFS_HOST_WDATA, d);
    swr(OFS_HOST_CMD, op);
    repeat (4) @(posedge clk_i);
    if (op == 8'h02) srd(OFS_HOST_RDATA);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    dop(8'h02, a, 8'h00);
    chk(r, exp);
  endtask
  task automatic t_mode;
    logic [7:0] v;
    rdc(OFS_RESERVED_PAD, 8'h00);
    rdc(OFS_INPUT_GAIN, 8'h50);
    rdc(OFS_LOCK_STATUS, {4'h0, REVISION_DEFAULT});
    for (int g = 0; g < 12; g++) begin
      v = {1'b0, 3'(g % 7), 4'(g)};
      dop(8'h01, OFS_INPUT_GAIN, v);
      rdc(OFS_INPUT_GAIN, v);
      chk({1'b0, sel, gain}, v);
    end
    dop(8'h01, OFS_INPUT_GAIN, 8'h70);
    srd(OFS_HOST_STAT);
    chk(r & 8'h02, 8'h02);
    rdc(OFS_INPUT_GAIN, 8'h4B);
  endtask
  task automatic t_flags;
    ev <= 8'hA5;
    ce <= 1'b1;
    @(posedge clk_i);
    ev <= 8'h00;
    ce <= 1'b0;
    rdc(OFS_ALARM_FLAGS, 8'hA5);
    rdc(OFS_ALARM_FLAGS, 8'h00);
    dop(8'h01, OFS_LOCK_STATUS, 8'h10);
    rdc(OFS_LOCK_STATUS, {4'h1, REVISION_DEFAULT});
    ls <= 1'b1;
    @(posedge clk_i);
    ls <= 1'b0;
    dop(8'h01, OFS_LOCK_STATUS, 8'h00);
    dop(8'h01, OFS_INPUT_GAIN, 8'h00);
    rdc(OFS_LOCK_STATUS, {4'h3, REVISION_DEFAULT});
    rdc(OFS_INPUT_GAIN, 8'h4B);
    chk({7'h0, flag}, 8'h01);
    lc <= 1'b1;
    @(posedge clk_i);
    lc <= 1'b0;
    dop(8'h01, OFS_LOCK_STATUS, 8'h00);
    rdc(OFS_LOCK_STATUS, {4'h0, REVISION_DEFAULT});
  endtask
  task automatic t_irq;
    swr(OFS_HOST_INT_MASK, 8'h01);
    // Drain events left by earlier scenarios so the raise below is real
    srd(OFS_HOST_INT_STAT);
    chk(r, 8'h03);
    chk({7'h0, irq}, 8'h00);
    dop(8'h01, OFS_RESERVED_PAD, 8'h00);
    chk({7'h0, irq}, 8'h01);
    srd(OFS_HOST_INT_STAT);
    chk(r & 8'h01, 8'h01);
    @(posedge clk_i);
    #1 chk({7'h0, irq}, 8'h00);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    t_mode;
    t_flags;
    t_irq;
    finish_test;
  end
endmodule
`default_nettype wire
